// *** core/fdrxf_cfg.svh ***
// Purpose: Register offsets, field positions and timing constants for the receive filter block
// Assumes: Avalon-MM word addressing, 16-bit data in the low lanes
// Notes: Included by the core and the bench
`ifndef FDRXF_CFG_SVH
`define FDRXF_CFG_SVH
`define FDRXF_OFS_MODE 4'h0
`define FDRXF_OFS_STAT 4'h1
`define FDRXF_OFS_CMD 4'h2
`define FDRXF_OFS_IND 4'h3
`define FDRXF_OFS_GRPH 4'h4
`define FDRXF_OFS_GRPM 4'h5
`define FDRXF_OFS_GRPL 4'h6
`define FDRXF_OFS_IND_S 4'h7
`define FDRXF_OFS_GRP_S 4'h8
`define FDRXF_OFS_INDM 4'h9
`define FDRXF_OFS_INDL 4'hA
`define FDRXF_AD_HI 10
`define FDRXF_AD_LO 8
`define FDRXF_SEL_BIT 7
`define FDRXF_CRY_BIT 6
`define FDRXF_GP_HI 5
`define FDRXF_GP_LO 4
`define FDRXF_MODE_RST 16'h0000
`define FDRXF_CMD_RESET 16'h0001
`define FDRXF_SEG_TOP 16
`define FDRXF_VX_SPLIT 4
`endif

// *** core/fdrxf_pkg.sv ***
// Purpose: Types shared by the receive filter block
// Assumes: Constants come from fdrxf_cfg.svh
// Notes: Filter and group codes as three- and two-bit enums
package fdrxf_pkg;
  typedef enum logic [2:0] {
    FDRXF_AD_MATCH = 3'h0,
    FDRXF_AD_OWN = 3'h1,
    FDRXF_AD_NSA_NOSELF = 3'h2,
    FDRXF_AD_NSA_ANY = 3'h3,
    FDRXF_AD_DISABLE = 3'h4,
    FDRXF_AD_RSVD = 3'h5,
    FDRXF_AD_LIMPROM = 3'h6,
    FDRXF_AD_PROM = 3'h7
  } fdrxf_ad_t;
  typedef enum logic [1:0] {
    FDRXF_GP_EXACT = 2'h0,
    FDRXF_GP_SOFT = 2'h1,
    FDRXF_GP_UP24 = 2'h2,
    FDRXF_GP_UP16 = 2'h3
  } fdrxf_gp_t;
  typedef enum logic [2:0] {
    FDRXF_ST_IDLE = 3'b001,
    FDRXF_ST_RECV = 3'b010,
    FDRXF_ST_ABORT = 3'b100
  } fdrxf_st_t;
endpackage : fdrxf_pkg

// *** core/fdrxf_core.sv ***
// Overview of operation
// - Mode fields at bits 10:8,7,6,5:4
// - Code 000 flushes unmatched DA unless external match
// - Broadcast always matches in match codes
// - DA matches long/short individual or group
// - Code 001 also keeps own transmitted frames
// - Code 010 NSA-aware, excludes own source
// - Code 011 NSA-aware, any source
// - Code 100 disables receive, aborts frame
// - Disabled: repeat C indicators unmodified
// - Code 110 limited promiscuous with exclusions
// - Code 111 keeps all, voids only here
// - Select 1 primary bus, 0 secondary
// - Bus select survives all resets
// - 21-bit timers split 5+4+4+4+4
// - 8-bit timer split 4+4
// - Segments step each byte clock, wrap
// - Carry split overrides timer hold
// - Group field selects partial multicast compare
// - Group code 01 accepts any group DA
// - Broadcast received under every group code
// - Command reset clears mode except select
//
// Purpose: Receive address filter, bus select and timer split test for an FDDI MAC
// Assumes: Frame fields arrive decoded and synchronous; match pins are asynchronous
// Notes: Registers on Avalon-MM, one word each; writes never wait, reads wait one cycle
`timescale 1ns/100ps
`include "fdrxf_cfg.svh"
module fdrxf_core
  import fdrxf_pkg::*;
#(
  parameter int RXW = 10, // Receive symbol bus width
  parameter int TW = 21, // Long timer width
  parameter int VW = 8 // Valid transmission timer width
)(
  input wire logic ref_clk_i, // 50 MHz byte clock
  input wire logic nrst_i, // Async reset, low
  input wire logic [3:0] avs_address_i, // Word address
  input wire logic avs_read_i, // Read strobe
  input wire logic avs_write_i, // Write strobe
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte lanes
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  input wire logic [RXW-1:0] rx_bus_primary_i, // Primary PHY bus
  input wire logic [RXW-1:0] rx_bus_secondary_i, // Secondary PHY bus
  output logic [RXW-1:0] media_rx_o, // Selected media input
  input wire logic ext_dest_match_in_i, // External DA match pin
  input wire logic ext_src_match_in_i, // External SA match pin
  input wire logic frm_start_i, // Frame start strobe
  input wire logic frm_addr_valid_i, // DA/SA fields valid strobe
  input wire logic frm_end_i, // Frame end strobe
  input wire logic [47:0] frm_da_i, // Destination address
  input wire logic [47:0] frm_sa_i, // Source address
  input wire logic frm_long_i, // 48-bit addressing
  input wire logic frm_nsa_i, // NSA frame type
  input wire logic frm_a_ind_i, // Received A indicator
  input wire logic frm_c_ind_i, // Received C indicator
  input wire logic frm_claim_i, // Claim frame
  input wire logic frm_null_beacon_i, // Null beacon frame
  input wire logic frm_void_i, // Void frame
  input wire logic frm_valid_i, // Frame valid at end
  output logic frm_keep_o, // Keep decision, set at the address fields
  output logic frm_flush_o, // Flush decision, at frame end
  output logic frm_abort_o, // Frame aborted pulse
  output logic receive_disable_cond_o, // Receive disabled level
  output logic c_ind_out_o, // C indicator repeated
  input wire logic timer_hold_i, // Hold request on timers
  input wire logic timer_tick_i, // Normal-mode timer step
  output logic [TW-1:0] token_rotation_timer_o, // Rotation timer
  output logic [TW-1:0] token_holding_timer_o, // Holding timer
  output logic [TW-1:0] sync_bandwidth_timer_o, // Synchronous timer
  output logic [VW-1:0] valid_xmit_timer_o // Valid transmission timer
);

  // Register state
  logic [15:0] mode_reg, mode_next;
  logic sel_reg, sel_next;
  logic [15:0] ind_h_reg, ind_h_next, ind_m_reg, ind_m_next, ind_l_reg, ind_l_next;
  logic [15:0] grp_h_reg, grp_h_next, grp_m_reg, grp_m_next, grp_l_reg, grp_l_next;
  logic [15:0] ind_s_reg, ind_s_next, grp_s_reg, grp_s_next;
  logic [31:0] rdata_reg, rdata_next;
  logic sel_seen_reg, sel_seen_next, rd_done_reg, rd_done_next;
  logic [47:0] ind_l48, grp_l48;
  fdrxf_ad_t ad_code;
  fdrxf_gp_t gp_code;
  logic carry_split;

  assign ad_code = fdrxf_ad_t'(mode_reg[`FDRXF_AD_HI:`FDRXF_AD_LO]);
  assign gp_code = fdrxf_gp_t'(mode_reg[`FDRXF_GP_HI:`FDRXF_GP_LO]);
  assign carry_split = mode_reg[`FDRXF_CRY_BIT];
  assign ind_l48 = {ind_h_reg, ind_m_reg, ind_l_reg};
  assign grp_l48 = {grp_h_reg, grp_m_reg, grp_l_reg};
  assign avs_waitrequest_o = avs_read_i && !rd_done_reg; // Reads stall one cycle so data stands at release
  assign avs_readdata_o = rdata_reg;

  // Register file next values; reads load the word into rdata_reg one edge before release
  always_comb
  begin
    logic wr;
    wr = 1'b0;
    mode_next = mode_reg;
    sel_next = sel_reg;
    sel_seen_next = sel_seen_reg;
    ind_h_next = ind_h_reg;
    ind_m_next = ind_m_reg;
    ind_l_next = ind_l_reg;
    grp_h_next = grp_h_reg;
    grp_m_next = grp_m_reg;
    grp_l_next = grp_l_reg;
    ind_s_next = ind_s_reg;
    grp_s_next = grp_s_reg;
    rdata_next = rdata_reg;
    rd_done_next = avs_read_i && !rd_done_reg; // Second read cycle ends the wait
    wr = avs_write_i && (avs_byteenable_i[1:0] == 2'b11);
    if (wr && avs_address_i == `FDRXF_OFS_MODE)
    begin
      mode_next = avs_writedata_i[15:0];
      sel_next = avs_writedata_i[`FDRXF_SEL_BIT];
      sel_seen_next = 1'b1;
    end
    else if (wr && avs_address_i == `FDRXF_OFS_CMD)
    begin
      if (avs_writedata_i[15:0] == `FDRXF_CMD_RESET)
        mode_next = `FDRXF_MODE_RST; // Select kept in sel_reg
    end
    else if (wr && avs_address_i == `FDRXF_OFS_IND)
      ind_h_next = avs_writedata_i[15:0];
    else if (wr && avs_address_i == `FDRXF_OFS_INDM)
      ind_m_next = avs_writedata_i[15:0];
    else if (wr && avs_address_i == `FDRXF_OFS_INDL)
      ind_l_next = avs_writedata_i[15:0];
    else if (wr && avs_address_i == `FDRXF_OFS_GRPH)
      grp_h_next = avs_writedata_i[15:0];
    else if (wr && avs_address_i == `FDRXF_OFS_GRPM)
      grp_m_next = avs_writedata_i[15:0];
    else if (wr && avs_address_i == `FDRXF_OFS_GRPL)
      grp_l_next = avs_writedata_i[15:0];
    else if (wr && avs_address_i == `FDRXF_OFS_IND_S)
      ind_s_next = avs_writedata_i[15:0];
    else if (wr && avs_address_i == `FDRXF_OFS_GRP_S)
      grp_s_next = avs_writedata_i[15:0];
    if (avs_read_i)
    begin
      if (avs_address_i == `FDRXF_OFS_MODE)
        rdata_next = {16'h0000, mode_reg[15:8], sel_reg, mode_reg[6:0]};
      else if (avs_address_i == `FDRXF_OFS_STAT)
        rdata_next = {28'h000_0000, c_ind_out_o, frm_keep_o, frm_flush_o, receive_disable_cond_o};
      else if (avs_address_i == `FDRXF_OFS_IND)
        rdata_next = {16'h0000, ind_h_reg};
      else if (avs_address_i == `FDRXF_OFS_INDM)
        rdata_next = {16'h0000, ind_m_reg};
      else if (avs_address_i == `FDRXF_OFS_INDL)
        rdata_next = {16'h0000, ind_l_reg};
      else if (avs_address_i == `FDRXF_OFS_GRPH)
        rdata_next = {16'h0000, grp_h_reg};
      else if (avs_address_i == `FDRXF_OFS_GRPM)
        rdata_next = {16'h0000, grp_m_reg};
      else if (avs_address_i == `FDRXF_OFS_GRPL)
        rdata_next = {16'h0000, grp_l_reg};
      else if (avs_address_i == `FDRXF_OFS_IND_S)
        rdata_next = {16'h0000, ind_s_reg};
      else if (avs_address_i == `FDRXF_OFS_GRP_S)
        rdata_next = {16'h0000, grp_s_reg};
      else
        rdata_next = 32'h0000_0000; // Unmapped reads zero
    end
  end

  // Select and its seen flag have no reset term so they survive hardware reset
  always_ff @(posedge ref_clk_i)
  begin
    sel_reg <= sel_next;
    sel_seen_reg <= sel_seen_next; // Unknown until first write; mux then falls to secondary
  end

  // Register file and read handshake state
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mode_reg <= `FDRXF_MODE_RST;
      rd_done_reg <= 1'b0;
      ind_h_reg <= 16'h0000;
      ind_m_reg <= 16'h0000;
      ind_l_reg <= 16'h0000;
      grp_h_reg <= 16'h0000;
      grp_m_reg <= 16'h0000;
      grp_l_reg <= 16'h0000;
      ind_s_reg <= 16'h0000;
      grp_s_reg <= 16'h0000;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      mode_reg <= mode_next;
      rd_done_reg <= rd_done_next;
      ind_h_reg <= ind_h_next;
      ind_m_reg <= ind_m_next;
      ind_l_reg <= ind_l_next;
      grp_h_reg <= grp_h_next;
      grp_m_reg <= grp_m_next;
      grp_l_reg <= grp_l_next;
      ind_s_reg <= ind_s_next;
      grp_s_reg <= grp_s_next;
      rdata_reg <= rdata_next;
    end
  end

  // Receive bus mux; primary when select is 1
  always_comb
  begin
    if (sel_seen_reg && sel_reg)
      media_rx_o = rx_bus_primary_i;
    else if (sel_seen_reg)
      media_rx_o = rx_bus_secondary_i;
    else
      media_rx_o = rx_bus_secondary_i;
  end

  // Match pins are asynchronous: two-flop synchronisers
  logic [1:0] xda_sync_reg, xsa_sync_reg;
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      xda_sync_reg <= 2'b00;
      xsa_sync_reg <= 2'b00;
    end
    else
    begin
      xda_sync_reg <= {xda_sync_reg[0], ext_dest_match_in_i};
      xsa_sync_reg <= {xsa_sync_reg[0], ext_src_match_in_i};
    end
  end

  // Address compare
  logic bcast, grp_bit, ind_hit, grp_hit, da_hit, sa_hit;
  always_comb
  begin
    bcast = frm_long_i ? (frm_da_i == 48'hFFFF_FFFF_FFFF) : (frm_da_i[15:0] == 16'hFFFF);
    grp_bit = frm_long_i ? frm_da_i[47] : frm_da_i[15];
    ind_hit = frm_long_i ? (frm_da_i == ind_l48) : (frm_da_i[15:0] == ind_s_reg);
    case (gp_code)
      FDRXF_GP_SOFT: grp_hit = grp_bit;
      FDRXF_GP_UP24: grp_hit = grp_bit && (frm_long_i ? frm_da_i[47:24] == grp_l48[47:24]
                                                     : frm_da_i[15:0] == grp_s_reg);
      FDRXF_GP_UP16: grp_hit = grp_bit && (frm_long_i ? frm_da_i[47:32] == grp_l48[47:32]
                                                     : frm_da_i[15:0] == grp_s_reg);
      default: grp_hit = frm_long_i ? (frm_da_i == grp_l48) : (frm_da_i[15:0] == grp_s_reg);
    endcase
    da_hit = ind_hit || grp_hit || bcast || xda_sync_reg[1];
    sa_hit = (frm_long_i ? (frm_sa_i == ind_l48) : (frm_sa_i[15:0] == ind_s_reg)) || xsa_sync_reg[1];
  end

  // Keep decision per filter code
  logic keep_c;
  always_comb
  begin
    case (ad_code)
      FDRXF_AD_MATCH: keep_c = da_hit;
      FDRXF_AD_OWN: keep_c = da_hit || sa_hit;
      FDRXF_AD_NSA_NOSELF: keep_c = frm_nsa_i ? (da_hit && !frm_a_ind_i) : (da_hit && !sa_hit);
      FDRXF_AD_NSA_ANY: keep_c = da_hit && (!frm_nsa_i || !frm_a_ind_i);
      FDRXF_AD_LIMPROM: keep_c = !frm_null_beacon_i && !frm_claim_i && !(sa_hit && !da_hit);
      FDRXF_AD_PROM: keep_c = 1'b1;
      default: keep_c = 1'b0; // Codes 100 and 101
    endcase
    if (frm_void_i && ad_code != FDRXF_AD_PROM)
      keep_c = 1'b0;
  end

  // Frame sequencer; disabling mid-frame aborts it
  fdrxf_st_t st_reg, st_next;
  logic keep_reg, keep_next, flush_reg, flush_next, abort_reg, abort_next;
  logic dis_reg, dis_next, cind_reg, cind_next, dis_c;
  assign dis_c = (ad_code == FDRXF_AD_DISABLE) || (ad_code == FDRXF_AD_RSVD);
  always_comb
  begin
    st_next = st_reg;
    keep_next = keep_reg;
    flush_next = 1'b0;
    abort_next = 1'b0;
    dis_next = dis_c;
    cind_next = frm_c_ind_i; // Repeated as received; never set here
    case (st_reg)
      FDRXF_ST_IDLE:
        if (frm_start_i && !dis_c)
        begin
          st_next = FDRXF_ST_RECV;
          keep_next = 1'b0;
        end
      FDRXF_ST_RECV:
        if (dis_c)
        begin
          st_next = FDRXF_ST_ABORT;
          abort_next = 1'b1;
          keep_next = 1'b0;
        end
        else if (frm_addr_valid_i)
          keep_next = keep_c;
        else if (frm_end_i)
        begin
          st_next = FDRXF_ST_IDLE;
          flush_next = !(keep_reg && frm_valid_i);
        end
      FDRXF_ST_ABORT:
        st_next = FDRXF_ST_IDLE;
      default:
        st_next = FDRXF_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_reg <= FDRXF_ST_IDLE;
      keep_reg <= 1'b0;
      flush_reg <= 1'b0;
      abort_reg <= 1'b0;
      dis_reg <= 1'b0;
      cind_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      keep_reg <= keep_next;
      flush_reg <= flush_next;
      abort_reg <= abort_next;
      dis_reg <= dis_next;
      cind_reg <= cind_next;
    end
  end

  assign frm_keep_o = keep_reg;
  assign frm_flush_o = flush_reg;
  assign frm_abort_o = abort_reg;
  assign receive_disable_cond_o = dis_reg;
  assign c_ind_out_o = cind_reg;

  // Timers; carry split breaks carries between nibble segments
  logic [TW-1:0] trt_reg, trt_next, tht_reg, tht_next, tms_reg, tms_next;
  logic [VW-1:0] tvx_reg, tvx_next;

  function automatic logic [TW-1:0] seg_inc(input logic [TW-1:0] v, input logic split);
    logic [TW-1:0] r;
    r = v + 1'b1;
    if (split)
    begin
      r[`FDRXF_SEG_TOP-1:0] = {v[15:12] + 4'h1, v[11:8] + 4'h1, v[7:4] + 4'h1, v[3:0] + 4'h1};
      r[TW-1:`FDRXF_SEG_TOP] = v[TW-1:`FDRXF_SEG_TOP] + 1'b1;
    end
    return r;
  endfunction : seg_inc

  always_comb
  begin
    trt_next = trt_reg;
    tht_next = tht_reg;
    tms_next = tms_reg;
    tvx_next = tvx_reg;
    if (carry_split)
    begin
      trt_next = seg_inc(trt_reg, 1'b1); // Hold ignored here
      tht_next = seg_inc(tht_reg, 1'b1);
      tms_next = seg_inc(tms_reg, 1'b1);
      tvx_next = {tvx_reg[VW-1:`FDRXF_VX_SPLIT] + 4'h1, tvx_reg[`FDRXF_VX_SPLIT-1:0] + 4'h1};
    end
    else if (timer_tick_i && !timer_hold_i)
    begin
      trt_next = seg_inc(trt_reg, 1'b0);
      tht_next = seg_inc(tht_reg, 1'b0);
      tms_next = seg_inc(tms_reg, 1'b0);
      tvx_next = tvx_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      trt_reg <= '0;
      tht_reg <= '0;
      tms_reg <= '0;
      tvx_reg <= '0;
    end
    else
    begin
      trt_reg <= trt_next;
      tht_reg <= tht_next;
      tms_reg <= tms_next;
      tvx_reg <= tvx_next;
    end
  end

  assign token_rotation_timer_o = trt_reg;
  assign token_holding_timer_o = tht_reg;
  assign sync_bandwidth_timer_o = tms_reg;
  assign valid_xmit_timer_o = tvx_reg;

  // Checks
  AST_SPLIT_LOW: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    carry_split && $past(carry_split) |-> trt_reg[3:0] == $past(trt_reg[3:0]) + 4'h1)
    else $error("low segment did not step");
  AST_SPLIT_TOP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    carry_split && $past(carry_split) && $past(trt_reg[15:0]) != 16'hFFFF
      |-> trt_reg[20:16] == $past(trt_reg[20:16]) + 5'h01)
    else $error("top segment did not step on its own");
  AST_TVX_SPLIT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    carry_split && $past(carry_split) && $past(tvx_reg[3:0]) != 4'hF
      |-> tvx_reg[7:4] == $past(tvx_reg[7:4]) + 4'h1)
    else $error("valid timer upper segment did not step");
  AST_HOLD_OVR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    carry_split && timer_hold_i |=> tht_reg != $past(tht_reg))
    else $error("hold froze split timer");
  AST_DIS_ABORT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    st_reg == FDRXF_ST_RECV && dis_c |=> frm_abort_o ##1 st_reg == FDRXF_ST_IDLE)
    else $error("frame not aborted on disable");
  AST_DIS_NOSTART: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    st_reg == FDRXF_ST_IDLE && dis_c |=> st_reg == FDRXF_ST_IDLE)
    else $error("frame started while disabled");
  AST_BUS_SEL: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    sel_seen_reg && sel_reg |-> media_rx_o == rx_bus_primary_i)
    else $error("primary bus not routed");
  AST_CMD_RST: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    avs_write_i && avs_address_i == `FDRXF_OFS_CMD && avs_writedata_i[15:0] == `FDRXF_CMD_RESET
      && avs_byteenable_i[1:0] == 2'b11 |=> mode_reg == 16'h0000 && sel_reg == $past(sel_reg))
    else $error("command reset wrong");
  AST_PROM_KEEP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    st_reg == FDRXF_ST_RECV && frm_addr_valid_i && !dis_c && ad_code == FDRXF_AD_PROM |=> keep_reg)
    else $error("promiscuous frame dropped");
  AST_CIND: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    dis_c |=> c_ind_out_o == $past(frm_c_ind_i))
    else $error("C indicator modified");
endmodule : fdrxf_core

// *** bench/fdrxf_phy_model.sv ***
// Purpose: Far-side model: two PHY receive buses and an external address matcher
// Assumes: Match requests come from the bench, one per frame
// Notes: Buses change every cycle so a stale mux selection shows at once
`timescale 1ns/100ps
module fdrxf_phy_model #(
  parameter int RXW = 10 // Bus width
)(
  input wire logic ref_clk_i, // Byte clock
  input wire logic da_req_i, // Request a DA match
  input wire logic sa_req_i, // Request an SA match
  output logic [RXW-1:0] bus_a_o, // Primary receive bus
  output logic [RXW-1:0] bus_b_o, // Secondary receive bus
  output logic da_match_o, // External DA match pin
  output logic sa_match_o // External SA match pin
);
  logic [RXW-1:0] cnt_reg = '0;
  logic da_reg = 1'h0;
  logic sa_reg = 1'h0;
  // Pins follow the request one edge later, held as long as it stands
  always @(posedge ref_clk_i)
  begin
    cnt_reg <= cnt_reg + 1'h1;
    da_reg <= da_req_i;
    sa_reg <= sa_req_i;
  end
  // Inverted pattern on the second bus keeps the two apart
  assign bus_a_o = cnt_reg;
  assign bus_b_o = ~cnt_reg;
  assign da_match_o = da_reg;
  assign sa_match_o = sa_reg;
endmodule : fdrxf_phy_model

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the receive filter block
// Assumes: Long addressing, valid frames, one bus access at a time
// Notes: Read data is taken at the edge that samples waitrequest low
`timescale 1ns/100ps
`include "fdrxf_cfg.svh"
module tb import fdrxf_pkg::*;;
  localparam logic [47:0] MA = 48'h1234_5678_9ABC;
  localparam logic [47:0] GA = 48'h8123_4567_89AB;
  localparam logic [47:0] OT = 48'h0246_8ACE_0246;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
  logic ref_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] ben = 4'hF;
  logic [31:0] rdat;
  logic wait_o;
  logic [9:0] bus_a, bus_b, media;
  logic da_req = 1'h0, sa_req = 1'h0, xda, xsa;
  logic start = 1'h0, aval = 1'h0, fend = 1'h0, cind = 1'h0, hold = 1'h0, tick = 1'h0;
  logic fvalid = 1'h1, flong = 1'h1;
  logic [47:0] da = '0, sa = '0;
  logic [4:0] flg = '0; // nsa, A, claim, null beacon, void
  logic keep, flush, abort, dis, cout;
  logic [20:0] token_rotation_timer, token_holding_timer, tsy, t0r, t0h, t0s;
  logic [7:0] valid_xmit_timer, t0v;
  logic [15:0] q;
  logic kp, fl;
  int num_errors = 0, cmp_count = 0, n_abort = 0;
  fdrxf_core u_fdrxf_core (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(ben), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o), .rx_bus_primary_i(bus_a), .rx_bus_secondary_i(bus_b), .media_rx_o(media),
    .ext_dest_match_in_i(xda), .ext_src_match_in_i(xsa), .frm_start_i(start), .frm_addr_valid_i(aval),
    .frm_end_i(fend), .frm_da_i(da), .frm_sa_i(sa), .frm_long_i(flong), .frm_nsa_i(flg[4]),
    .frm_a_ind_i(flg[3]), .frm_c_ind_i(cind), .frm_claim_i(flg[2]), .frm_null_beacon_i(flg[1]),
    .frm_void_i(flg[0]), .frm_valid_i(fvalid), .frm_keep_o(keep), .frm_flush_o(flush), .frm_abort_o(abort),
    .receive_disable_cond_o(dis), .c_ind_out_o(cout), .timer_hold_i(hold), .timer_tick_i(tick),
    .token_rotation_timer_o(token_rotation_timer), .token_holding_timer_o(token_holding_timer), .sync_bandwidth_timer_o(tsy),
    .valid_xmit_timer_o(valid_xmit_timer));
  fdrxf_phy_model u_fdrxf_phy_model (.ref_clk_i(ref_clk_i), .da_req_i(da_req), .sa_req_i(sa_req),
    .bus_a_o(bus_a), .bus_b_o(bus_b), .da_match_o(xda), .sa_match_o(xsa));
  // Free-running 50 MHz clock
  initial forever #10 ref_clk_i = ~ref_clk_i;
  // Abort pulses counted as they come, since a bus access may hide them
  always @(posedge ref_clk_i) if (abort === 1'h1) n_abort++;
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One bus access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {16'h0000, d};
    @(posedge ref_clk_i);
    while (wait_o !== 1'h0)
    begin
      n++;
      if (n > 16)
      begin
        num_errors++;
        end_sim();
      end
      @(posedge ref_clk_i);
    end
    q = rdat[15:0];
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge ref_clk_i);
  endtask : bus
  function automatic logic [15:0] md(input logic [2:0] c, input logic [1:0] g);
    return {5'h00, c, 1'h1, 1'h0, g, 4'h0}; // Carry split left clear in normal use
  endfunction : md
  function automatic logic [20:0] seg21(input logic [20:0] v, input int n);
    return {v[20:16] + 5'(n), v[15:12] + 4'(n), v[11:8] + 4'(n), v[7:4] + 4'(n), v[3:0] + 4'(n)};
  endfunction : seg21
  // Frame walk: start, address fields, end; keep and flush sampled where they stand
  task automatic frame(input logic [47:0] d, input logic [47:0] s, input logic [4:0] f);
    @(posedge ref_clk_i);
    da <= d;
    sa <= s;
    flg <= f;
    start <= 1'h1;
    @(posedge ref_clk_i);
    start <= 1'h0;
    aval <= 1'h1;
    @(posedge ref_clk_i);
    aval <= 1'h0;
    @(posedge ref_clk_i);
    kp = keep;
    fend <= 1'h1;
    @(posedge ref_clk_i);
    fend <= 1'h0;
    @(posedge ref_clk_i);
    fl = flush;
  endtask : frame
  // Match pins raised three cycles ahead so the synchroniser has settled
  task automatic run(input logic [15:0] m, input logic [47:0] d, input logic [47:0] s, input logic [4:0] f,
                     input logic [1:0] x, input logic k);
    bus(1'h1, `FDRXF_OFS_MODE, m);
    {sa_req, da_req} <= x;
    repeat (3) @(posedge ref_clk_i);
    frame(d, s, f);
    chk("flush", fl, !k);
    {sa_req, da_req} <= 2'h0;
  endtask : run
  initial
  begin
    repeat (100000) @(posedge ref_clk_i);
    num_errors++;
    end_sim();
  end
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'h1;
    // Field placement, bus select, refused write, command reset
    bus(1'h1, `FDRXF_OFS_MODE, 16'h07F0);
    bus(1'h0, `FDRXF_OFS_MODE, 16'h0000);
    chk("mode", q, 16'h07F0);
    chk("media a", media, bus_a);
    bus(1'h1, `FDRXF_OFS_MODE, 16'h0000);
    chk("media b", media, bus_b);
    bus(1'h1, `FDRXF_OFS_MODE, 16'h07F0);
    ben <= 4'h1;
    bus(1'h1, `FDRXF_OFS_MODE, 16'h0000);
    ben <= 4'hF;
    bus(1'h0, `FDRXF_OFS_MODE, 16'h0000);
    chk("lane refused", q, 16'h07F0);
    bus(1'h1, `FDRXF_OFS_CMD, `FDRXF_CMD_RESET);
    bus(1'h0, `FDRXF_OFS_MODE, 16'h0000);
    chk("mode after cmd", q, 16'h0080);
    bus(1'h0, 4'hF, 16'h0000);
    chk("unmapped", q, 16'h0000);
    nrst_i <= 1'h0;
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'h1;
    chk("media hw reset", media, bus_a);
    // Station addresses
    bus(1'h1, `FDRXF_OFS_IND, MA[47:32]);
    bus(1'h1, `FDRXF_OFS_INDM, MA[31:16]);
    bus(1'h1, `FDRXF_OFS_INDL, MA[15:0]);
    bus(1'h1, `FDRXF_OFS_GRPH, GA[47:32]);
    bus(1'h1, `FDRXF_OFS_GRPM, GA[31:16]);
    bus(1'h1, `FDRXF_OFS_GRPL, GA[15:0]);
    // Filter codes; ext bits are {sa, da}
    run(md(3'h0, 2'h0), OT, OT, 5'h00, 2'h0, 1'h0);
    run(md(3'h0, 2'h0), MA, OT, 5'h00, 2'h0, 1'h1);
    run(md(3'h0, 2'h0), GA, OT, 5'h00, 2'h0, 1'h1);
    run(md(3'h0, 2'h0), BC, OT, 5'h00, 2'h0, 1'h1);
    run(md(3'h0, 2'h0), OT, OT, 5'h00, 2'h1, 1'h1);
    run(md(3'h0, 2'h0), OT, MA, 5'h00, 2'h0, 1'h0);
    run(md(3'h1, 2'h0), OT, MA, 5'h00, 2'h0, 1'h1);
    run(md(3'h1, 2'h0), OT, OT, 5'h00, 2'h2, 1'h1);
    run(md(3'h2, 2'h0), MA, MA, 5'h00, 2'h0, 1'h0);
    run(md(3'h2, 2'h0), MA, OT, 5'h18, 2'h0, 1'h0);
    run(md(3'h2, 2'h0), MA, OT, 5'h10, 2'h0, 1'h1);
    run(md(3'h3, 2'h0), MA, MA, 5'h00, 2'h0, 1'h1);
    run(md(3'h3, 2'h0), MA, OT, 5'h18, 2'h0, 1'h0);
    run(md(3'h6, 2'h0), OT, OT, 5'h00, 2'h0, 1'h1);
    run(md(3'h6, 2'h0), MA, OT, 5'h04, 2'h0, 1'h0);
    run(md(3'h6, 2'h0), OT, OT, 5'h02, 2'h0, 1'h0);
    run(md(3'h6, 2'h0), OT, MA, 5'h00, 2'h0, 1'h0);
    // Promiscuous keeps claim and void frames; limited promiscuous flushes void
    run(md(3'h7, 2'h0), OT, MA, 5'h04, 2'h0, 1'h1);
    run(md(3'h7, 2'h0), OT, OT, 5'h01, 2'h0, 1'h1);
    run(md(3'h6, 2'h0), MA, OT, 5'h01, 2'h0, 1'h0);
    // Group partial compare: low 24 bits differ, then bits 31:24 too
    run(md(3'h0, 2'h0), 48'h8123_4500_0000, OT, 5'h00, 2'h0, 1'h0);
    run(md(3'h0, 2'h2), 48'h8123_4500_0000, OT, 5'h00, 2'h0, 1'h1);
    run(md(3'h0, 2'h2), 48'h8123_0000_0000, OT, 5'h00, 2'h0, 1'h0);
    run(md(3'h0, 2'h3), 48'h8123_0000_0000, OT, 5'h00, 2'h0, 1'h1);
    run(md(3'h0, 2'h1), 48'h8000_0000_0001, OT, 5'h00, 2'h0, 1'h1);
    run(md(3'h0, 2'h1), OT, OT, 5'h00, 2'h0, 1'h0);
    run(md(3'h0, 2'h3), BC, OT, 5'h00, 2'h0, 1'h1);
    run(md(3'h0, 2'h2), BC, OT, 5'h00, 2'h0, 1'h1);
    // Disable in mid-frame, then repeat of C and no reception
    @(posedge ref_clk_i);
    da <= MA;
    start <= 1'h1;
    @(posedge ref_clk_i);
    start <= 1'h0;
    bus(1'h1, `FDRXF_OFS_MODE, md(3'h4, 2'h0));
    repeat (4) @(posedge ref_clk_i);
    chk("abort count", n_abort, 1);
    chk("disabled", dis, 1'h1);
    cind <= 1'h1;
    @(posedge ref_clk_i);
    cind <= 1'h0;
    #1 chk("c repeat", cout, 1'h1);
    frame(MA, OT, 5'h00);
    chk("no keep", kp, 1'h0);
    chk("no flush", fl, 1'h0);
    bus(1'h1, `FDRXF_OFS_MODE, md(3'h0, 2'h0));
    bus(1'h1, `FDRXF_OFS_MODE, md(3'h5, 2'h0));
    @(posedge ref_clk_i);
    chk("reserved", dis, 1'h1);
    // Carry split with hold raised: segments step and wrap
    bus(1'h1, `FDRXF_OFS_MODE, 16'h00C0);
    hold <= 1'h1;
    @(posedge ref_clk_i);
    #1 {t0r, t0h, t0s, t0v} = {token_rotation_timer, token_holding_timer, tsy, valid_xmit_timer};
    repeat (20) @(posedge ref_clk_i);
    #1 chk("rotation", token_rotation_timer, seg21(t0r, 20));
    chk("holding", token_holding_timer, seg21(t0h, 20));
    chk("sync", tsy, seg21(t0s, 20));
    chk("valid", valid_xmit_timer, {t0v[7:4] + 4'h4, t0v[3:0] + 4'h4});
    end_sim();
  end
endmodule : tb
